// ---- src/mra_params.svh ----
/*
 * constants of the measurement read-out and self-calibration block.
 * assumes a 200 MHz core clock and inclusion by its bare name.
 */
// Summary of operation
// - i2c read streams eighteen bytes, every two data bytes followed by crc
// - modbus read returns six words, co2, temperature, humidity, upper word first
// - i2c host may nack then stop after any byte; device stops sending
// - each 32-bit value goes out most significant byte first
// - command with 16-bit argument, 1 activates, 0 deactivates self-calibration
// - self-calibration stays off until the host first activates it
// - self-calibration on/off state is kept in non-volatile storage
// - enabled at power-down means self-calibration resumes after power-up
// - self-calibration runs only in continuous measurement mode
// - first parameter search lasts at least seven days before applying
// - power loss aborts the search, which restarts from the beginning
// - derived parameters are stored in non-volatile storage
// - latest parameters stay applied whether or not the feature is enabled
// - newest of self-calibration and external recalibration replaces the other; power-up restores stored self-calibration over a later external one
`ifndef MRA_PARAMS_SVH
`define MRA_PARAMS_SVH
// register offset and command codes
`define MRA_ACAL_ADDR 16'h003A
`define MRA_ACAL_CMD 16'h5306
`define MRA_MB_FC_WRITE 8'h06
// reset and enable values
`define MRA_ACAL_RESET 16'h0000
`define MRA_ACAL_ON 16'h0001
// stream layout
`define MRA_I2C_PAIRS 6
`define MRA_MB_WORDS 6
`define MRA_CRC_POS 2
// crc
`define MRA_CRC_INIT 8'hFF
`define MRA_CRC_POLY 8'h31
// timing
`define MRA_CLK_PERIOD_NS 5
`define MRA_SEC_NS 1000000000
`define MRA_SEARCH_DAYS 7
`define MRA_DAY_SEC 86400
`define MRA_READ_WAIT_MS 3
`endif

// ---- src/mra_pkg.sv ----
/*
 * types of the measurement read-out and self-calibration block.
 * assumes nothing beyond a systemverilog compiler.
 */
package mra_pkg;
   typedef enum logic [0:0] {I2C_IDLE, I2C_SEND} mra_i2c_state_t;
   typedef enum logic [0:0] {MB_IDLE, MB_SEND} mra_mb_state_t;
   typedef enum logic [1:0] {CAL_FACTORY, CAL_EXT, CAL_AUTO} mra_cal_src_t;
endpackage

// ---- src/mra_crc8.sv ----
/*
 * crc-8 of one 16-bit word, msb first, polynomial 0x31, init 0xFF.
 * assumes a combinational use inside the read-out stream.
 */
`timescale 1ns/1ps
`include "mra_params.svh"
module mra_crc8 (
   input wire logic [15:0] data_in,
   output logic [7:0] crc_out
);
   logic [7:0] chain [0:16];

   // ***************************************
   // bit-serial crc unrolled over the word
   // ***************************************
   assign chain[0] = `MRA_CRC_INIT;
   for (genvar i = 0; i < 16; i++) begin : g_bit
      logic fb;
      assign fb = chain[i][7] ^ data_in[15 - i];
      assign chain[i + 1] = {chain[i][6:0], 1'b0} ^ (fb ? `MRA_CRC_POLY : 8'h00);
   end
   assign crc_out = chain[16];
endmodule

// ---- src/mra_top.sv ----
/*
 * measurement read-out framing and self-calibration control.
 * assumes a byte-level i2c engine and a frame-level modbus engine outside,
 * measurement values already in ieee-754 form, and non-volatile storage
 * whose contents are presented on nv_*_in at reset release.
 */
`timescale 1ns/1ps
`include "mra_params.svh"
module mra_top #(
   parameter int CYC_PER_SEC = `MRA_SEC_NS / `MRA_CLK_PERIOD_NS,
   parameter int SEARCH_SEC = `MRA_SEARCH_DAYS * `MRA_DAY_SEC
) (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic sel_modbus_in,
   input wire logic [31:0] co2_in,
   input wire logic [31:0] temp_in,
   input wire logic [31:0] hum_in,
   input wire logic i2c_rd_start_in,
   input wire logic i2c_byte_req_in,
   input wire logic i2c_nack_in,
   input wire logic i2c_stop_in,
   output logic [7:0] i2c_byte_out,
   output logic i2c_byte_valid_out,
   output logic i2c_busy_out,
   input wire logic mb_rd_start_in,
   output logic [15:0] mb_word_out,
   output logic mb_word_valid_out,
   output logic [2:0] mb_word_idx_out,
   input wire logic cmd_valid_in,
   input wire logic [7:0] cmd_func_in,
   input wire logic [15:0] cmd_code_in,
   input wire logic [15:0] cmd_arg_in,
   output logic cmd_ack_out,
   output logic [15:0] auto_calibration_enable_out,
   input wire logic cont_mode_in,
   input wire logic frc_in,
   input wire logic nv_acal_in,
   input wire logic nv_params_in,
   output logic nv_acal_wr_out,
   output logic nv_acal_data_out,
   output logic nv_params_wr_out,
   output logic acal_active_out,
   output mra_pkg::mra_cal_src_t cal_source_out
);
   import mra_pkg::*;

   // ***************************************
   // read-out stream
   // ***************************************
   logic [31:0] snap [0:2];
   logic [31:0] next_snap [0:2];
   mra_i2c_state_t i2c_state, next_i2c_state;
   mra_mb_state_t mb_state, next_mb_state;
   logic [2:0] pair, next_pair;
   logic [1:0] pos, next_pos;
   logic [2:0] mb_idx, next_mb_idx;
   logic [7:0] next_i2c_byte;
   logic next_i2c_byte_valid, next_i2c_busy;
   logic [15:0] next_mb_word;
   logic next_mb_word_valid;
   logic [2:0] next_mb_word_idx;
   logic [15:0] i2c_word;
   logic [7:0] i2c_crc;

   // word n of the six: value n/2, upper word on even n
   function automatic logic [15:0] pick_word(input logic [31:0] v0, input logic [31:0] v1,
                                             input logic [31:0] v2, input logic [2:0] n);
      logic [31:0] v;
      v = (n[2:1] == 2'd0) ? v0 : ((n[2:1] == 2'd1) ? v1 : v2);
      pick_word = n[0] ? v[15:0] : v[31:16];
   endfunction

   assign i2c_word = pick_word(snap[0], snap[1], snap[2], pair);

   mra_crc8 u_crc (
      .data_in(i2c_word),
      .crc_out(i2c_crc)
   );

   // stream next state
   always_comb begin
      next_snap = snap;
      next_i2c_state = i2c_state;
      next_mb_state = mb_state;
      next_pair = pair;
      next_pos = pos;
      next_mb_idx = mb_idx;
      next_i2c_byte = i2c_byte_out;
      next_i2c_byte_valid = 1'b0;
      next_mb_word = mb_word_out;
      next_mb_word_valid = 1'b0;
      next_mb_word_idx = mb_word_idx_out;
      // values are forwarded bit for bit, already single precision
      if ((i2c_rd_start_in && i2c_state == I2C_IDLE && !sel_modbus_in) ||
          (mb_rd_start_in && mb_state == MB_IDLE && sel_modbus_in)) begin
         next_snap[0] = co2_in;
         next_snap[1] = temp_in;
         next_snap[2] = hum_in;
      end
      unique case (i2c_state)
         I2C_IDLE: begin
            if (i2c_rd_start_in && !sel_modbus_in) begin
               next_i2c_state = I2C_SEND;
               next_pair = 3'd0;
               next_pos = 2'd0;
            end
         end
         I2C_SEND: begin
            if (i2c_nack_in || i2c_stop_in) begin
               next_i2c_state = I2C_IDLE;
            end else if (i2c_byte_req_in) begin
               next_i2c_byte_valid = 1'b1;
               // upper byte, lower byte, then crc of the pair
               unique case (pos)
                  2'd0: next_i2c_byte = i2c_word[15:8];
                  2'd1: next_i2c_byte = i2c_word[7:0];
                  default: next_i2c_byte = i2c_crc;
               endcase
               if (pos == 2'(`MRA_CRC_POS)) begin
                  next_pos = 2'd0;
                  next_pair = pair + 3'd1;
                  if (pair == 3'(`MRA_I2C_PAIRS - 1)) begin
                     next_i2c_state = I2C_IDLE;
                  end
               end else begin
                  next_pos = pos + 2'd1;
               end
            end
         end
      endcase
      unique case (mb_state)
         MB_IDLE: begin
            if (mb_rd_start_in && sel_modbus_in) begin
               next_mb_state = MB_SEND;
               next_mb_idx = 3'd0;
            end
         end
         MB_SEND: begin
            // six words on consecutive cycles
            next_mb_word = pick_word(snap[0], snap[1], snap[2], mb_idx);
            next_mb_word_valid = 1'b1;
            next_mb_word_idx = mb_idx;
            next_mb_idx = mb_idx + 3'd1;
            if (mb_idx == 3'(`MRA_MB_WORDS - 1)) begin
               next_mb_state = MB_IDLE;
            end
         end
      endcase
      next_i2c_busy = (next_i2c_state == I2C_SEND);
   end

   // stream registers
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         snap <= '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
         i2c_state <= I2C_IDLE;
         mb_state <= MB_IDLE;
         pair <= 3'd0;
         pos <= 2'd0;
         mb_idx <= 3'd0;
         i2c_byte_out <= 8'h00;
         i2c_byte_valid_out <= 1'b0;
         i2c_busy_out <= 1'b0;
         mb_word_out <= 16'h0000;
         mb_word_valid_out <= 1'b0;
         mb_word_idx_out <= 3'd0;
      end else begin
         snap <= next_snap;
         i2c_state <= next_i2c_state;
         mb_state <= next_mb_state;
         pair <= next_pair;
         pos <= next_pos;
         mb_idx <= next_mb_idx;
         i2c_byte_out <= next_i2c_byte;
         i2c_byte_valid_out <= next_i2c_byte_valid;
         i2c_busy_out <= next_i2c_busy;
         mb_word_out <= next_mb_word;
         mb_word_valid_out <= next_mb_word_valid;
         mb_word_idx_out <= next_mb_word_idx;
      end
   end

   // ***************************************
   // self-calibration control
   // ***************************************
   logic loaded, next_loaded;
   logic [15:0] next_acal_en;
   logic next_cmd_ack, next_nv_acal_wr, next_nv_acal_data, next_nv_params_wr;
   logic [31:0] cyc_cnt, next_cyc_cnt, sec_cnt, next_sec_cnt;
   logic next_acal_active, sec_tick, found, cmd_hit;
   mra_cal_src_t next_cal_source;

   // i2c command code or modbus single-register write
   assign cmd_hit = cmd_valid_in && (cmd_arg_in <= `MRA_ACAL_ON) &&
                    (sel_modbus_in ? (cmd_func_in == `MRA_MB_FC_WRITE &&
                                      cmd_code_in == `MRA_ACAL_ADDR)
                                   : (cmd_code_in == `MRA_ACAL_CMD));
   assign sec_tick = acal_active_out && (cyc_cnt == 32'(CYC_PER_SEC - 1));
   assign found = sec_tick && (sec_cnt == 32'(SEARCH_SEC - 1));

   // calibration next state
   always_comb begin
      next_loaded = 1'b1;
      next_acal_en = auto_calibration_enable_out;
      next_cmd_ack = 1'b0;
      next_nv_acal_wr = 1'b0;
      next_nv_acal_data = nv_acal_data_out;
      next_nv_params_wr = 1'b0;
      next_cyc_cnt = cyc_cnt;
      next_sec_cnt = sec_cnt;
      next_cal_source = cal_source_out;
      if (!loaded) begin
         // stored state and parameters picked up once after power-up
         next_acal_en = nv_acal_in ? `MRA_ACAL_ON : `MRA_ACAL_RESET;
         next_nv_acal_data = nv_acal_in;
         next_cal_source = nv_params_in ? CAL_AUTO : CAL_FACTORY;
      end else begin
         if (cmd_hit) begin
            next_acal_en = cmd_arg_in;
            next_cmd_ack = 1'b1;
            next_nv_acal_wr = 1'b1;
            next_nv_acal_data = cmd_arg_in[0];
         end
         // one-second enable, counting only while active
         if (acal_active_out) begin
            next_cyc_cnt = sec_tick ? 32'd0 : cyc_cnt + 32'd1;
            if (sec_tick) begin
               next_sec_cnt = found ? 32'd0 : sec_cnt + 32'd1;
            end
         end
         // latest of the two calibration sources wins
         if (found) begin
            next_cal_source = CAL_AUTO;
            next_nv_params_wr = 1'b1;
         end else if (frc_in) begin
            next_cal_source = CAL_EXT;
         end
      end
      next_acal_active = next_loaded && next_acal_en[0] && cont_mode_in;
   end

   // calibration registers; reset stands for power loss
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         loaded <= 1'b0;
         auto_calibration_enable_out <= `MRA_ACAL_RESET;
         cmd_ack_out <= 1'b0;
         nv_acal_wr_out <= 1'b0;
         nv_acal_data_out <= 1'b0;
         nv_params_wr_out <= 1'b0;
         cyc_cnt <= 32'd0;
         sec_cnt <= 32'd0;
         acal_active_out <= 1'b0;
         cal_source_out <= CAL_FACTORY;
      end else begin
         loaded <= next_loaded;
         auto_calibration_enable_out <= next_acal_en;
         cmd_ack_out <= next_cmd_ack;
         nv_acal_wr_out <= next_nv_acal_wr;
         nv_acal_data_out <= next_nv_acal_data;
         nv_params_wr_out <= next_nv_params_wr;
         cyc_cnt <= next_cyc_cnt;
         sec_cnt <= next_sec_cnt;
         acal_active_out <= next_acal_active;
         cal_source_out <= next_cal_source;
      end
   end

   // ***************************************
   // assertions
   // ***************************************
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (reset_in);
   property p_last_byte;
      i2c_busy_out && !i2c_nack_in && !i2c_stop_in && i2c_byte_req_in &&
      pair == 3'd5 && pos == 2'd2 |=> !i2c_busy_out && i2c_byte_valid_out;
   endproperty
   a_last_byte: assert property (p_last_byte) else $error("stream not ended at byte 18");
   property p_mb_six;
      mb_rd_start_in && sel_modbus_in && mb_state == MB_IDLE
      |=> ##1 mb_word_valid_out[*6] ##1 !mb_word_valid_out;
   endproperty
   a_mb_six: assert property (p_mb_six) else $error("modbus did not send six words");
   property p_mb_first;
      mb_rd_start_in && sel_modbus_in && mb_state == MB_IDLE
      |=> ##1 mb_word_out == $past(co2_in[31:16], 2) && mb_word_idx_out == 3'd0;
   endproperty
   a_mb_first: assert property (p_mb_first) else $error("first modbus word wrong");
   property p_abort;
      i2c_busy_out && (i2c_nack_in || i2c_stop_in) |=> !i2c_busy_out ##1 !i2c_byte_valid_out;
   endproperty
   a_abort: assert property (p_abort) else $error("stream continued after abort");
   property p_msb_first;
      i2c_busy_out && !i2c_nack_in && !i2c_stop_in && i2c_byte_req_in &&
      pair == 3'd0 && pos == 2'd0 |=> i2c_byte_out == snap[0][31:24];
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("first byte not co2 msb");
   property p_cmd;
      loaded && cmd_hit |=> cmd_ack_out && auto_calibration_enable_out == $past(cmd_arg_in);
   endproperty
   a_cmd: assert property (p_cmd) else $error("calibration command not applied");
   property p_off_at_reset;
      $past(reset_in) |-> auto_calibration_enable_out == `MRA_ACAL_RESET && sec_cnt == 32'd0;
   endproperty
   a_off_at_reset: assert property (p_off_at_reset) else $error("not off after reset");
   property p_nv_wr;
      loaded && cmd_hit |=> nv_acal_wr_out && nv_acal_data_out == $past(cmd_arg_in[0]);
   endproperty
   a_nv_wr: assert property (p_nv_wr) else $error("enable not written to storage");
   property p_resume;
      !loaded |=> auto_calibration_enable_out[0] == $past(nv_acal_in);
   endproperty
   a_resume: assert property (p_resume) else $error("stored enable not resumed");
   property p_cont;
      !cont_mode_in |=> !acal_active_out;
   endproperty
   a_cont: assert property (p_cont) else $error("calibration active outside continuous");
   // a store pulse only ever follows the last cycle of the last second of a search
   property p_found;
      nv_params_wr_out |-> $past(acal_active_out) && $past(cyc_cnt) == 32'(CYC_PER_SEC - 1) &&
      $past(sec_cnt) == 32'(SEARCH_SEC - 1);
   endproperty
   a_found: assert property (p_found) else $error("parameters found early");
   property p_store;
      loaded && found |=> nv_params_wr_out && cal_source_out == CAL_AUTO;
   endproperty
   a_store: assert property (p_store) else $error("parameters not stored");
   property p_keep;
      loaded && cal_source_out == CAL_AUTO && !frc_in |=> cal_source_out == CAL_AUTO;
   endproperty
   a_keep: assert property (p_keep) else $error("parameters dropped");
   property p_frc;
      loaded && frc_in && !found |=> cal_source_out == CAL_EXT;
   endproperty
   a_frc: assert property (p_frc) else $error("external recalibration ignored");

   c_i2c_full: cover property (i2c_busy_out ##1 !i2c_busy_out && i2c_byte_valid_out);
   c_i2c_abort: cover property (i2c_busy_out && i2c_nack_in);
   c_mb_read: cover property (mb_word_valid_out && mb_word_idx_out == 3'd5);
   c_found: cover property (found);
endmodule

// ---- tb/mra_host.sv ----
/*
 * host model driving read and command requests into the block.
 * assumes one shared clock; strobes change just after a rising edge.
 */
`timescale 1ns/1ps
module mra_host #(
   parameter int WAIT_CYC = 4
) (
   input wire logic core_clk_in,
   input wire logic i2c_byte_valid_in,
   input wire logic [7:0] i2c_byte_in,
   input wire logic cmd_ack_in,
   output logic i2c_rd_start_out,
   output logic i2c_byte_req_out,
   output logic i2c_nack_out,
   output logic i2c_stop_out,
   output logic mb_rd_start_out,
   output logic cmd_valid_out,
   output logic [7:0] cmd_func_out,
   output logic [15:0] cmd_code_out,
   output logic [15:0] cmd_arg_out
);
   // all strobes quiet from time zero
   initial begin
      {i2c_rd_start_out, i2c_byte_req_out, i2c_nack_out, i2c_stop_out} = 4'h0;
      {mb_rd_start_out, cmd_valid_out, cmd_func_out} = 10'h000;
      {cmd_code_out, cmd_arg_out} = 32'h0000_0000;
   end
   // read header once the measurement is done and the wait has run out
   task automatic i2c_open();
      repeat (WAIT_CYC) @(posedge core_clk_in);
      i2c_rd_start_out <= 1'b1;
      @(posedge core_clk_in);
      i2c_rd_start_out <= 1'b0;
   endtask
   // ask for one byte, take it a cycle later
   task automatic i2c_get(output logic [7:0] b, output logic v);
      @(posedge core_clk_in);
      i2c_byte_req_out <= 1'b1;
      @(posedge core_clk_in);
      i2c_byte_req_out <= 1'b0;
      @(negedge core_clk_in);
      b = i2c_byte_in;
      v = i2c_byte_valid_in;
   endtask
   // not-acknowledge, then stop
   task automatic i2c_abort();
      @(posedge core_clk_in);
      i2c_nack_out <= 1'b1;
      @(posedge core_clk_in);
      i2c_nack_out <= 1'b0;
      i2c_stop_out <= 1'b1;
      @(posedge core_clk_in);
      i2c_stop_out <= 1'b0;
   endtask
   // modbus read-measurement frame
   task automatic mb_open();
      @(posedge core_clk_in);
      mb_rd_start_out <= 1'b1;
      @(posedge core_clk_in);
      mb_rd_start_out <= 1'b0;
   endtask
   // one command; fields scrambled once taken so stale values never match
   task automatic cmd(input logic [7:0] f, input logic [15:0] c, input logic [15:0] a,
                      output logic ack);
      @(posedge core_clk_in);
      cmd_valid_out <= 1'b1;
      cmd_func_out <= f;
      cmd_code_out <= c;
      cmd_arg_out <= a;
      @(posedge core_clk_in);
      cmd_valid_out <= 1'b0;
      cmd_func_out <= ~f;
      cmd_code_out <= ~c;
      cmd_arg_out <= ~a;
      @(negedge core_clk_in);
      ack = cmd_ack_in;
   endtask
endmodule

// ---- tb/test_measurement_readout_asc_control.sv ----
/*
 * testbench of the read-out and self-calibration block.
 * assumes the host model in tb/ and shortened second and search counts.
 */
`timescale 1ns/1ps
module test_measurement_readout_asc_control;
   import mra_pkg::*;
   localparam int CPS = 4;
   localparam int SS = 3;
   localparam int LO = CPS * SS - 1;
   localparam int HI = CPS * SS + 4;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic sel = 1'b0;
   logic cont = 1'b0;
   logic frc = 1'b0;
   logic nv_acal = 1'b0;
   logic nv_par = 1'b0;
   logic [31:0] co2 = 32'h43DB8C2E;
   logic [31:0] temp = 32'h41D9E7FF;
   logic [31:0] hum = 32'h42433A1B;
   logic rd_st, b_req, nack, stop, mb_st, c_val, b_val, busy, c_ack, mb_val;
   logic nv_wr, nv_dat, nvp_wr, acal_act;
   logic [7:0] c_func, b_dat;
   logic [15:0] c_code, c_arg, mb_word, acal_en;
   logic [2:0] mb_idx;
   mra_cal_src_t cal_src;
   int fail_count = 0;
   int checks_done = 0;

   always #2.5 core_clk = ~core_clk;
   // non-volatile storage beside the block
   always @(posedge core_clk) begin
      if (nv_wr === 1'b1) nv_acal <= nv_dat;
      if (nvp_wr === 1'b1) nv_par <= 1'b1;
   end

   mra_top #(.CYC_PER_SEC(CPS), .SEARCH_SEC(SS)) u_dut (
      .core_clk_in(core_clk), .reset_in(rst), .sel_modbus_in(sel),
      .co2_in(co2), .temp_in(temp), .hum_in(hum),
      .i2c_rd_start_in(rd_st), .i2c_byte_req_in(b_req), .i2c_nack_in(nack),
      .i2c_stop_in(stop), .i2c_byte_out(b_dat), .i2c_byte_valid_out(b_val),
      .i2c_busy_out(busy), .mb_rd_start_in(mb_st), .mb_word_out(mb_word),
      .mb_word_valid_out(mb_val), .mb_word_idx_out(mb_idx), .cmd_valid_in(c_val),
      .cmd_func_in(c_func), .cmd_code_in(c_code), .cmd_arg_in(c_arg), .cmd_ack_out(c_ack),
      .auto_calibration_enable_out(acal_en), .cont_mode_in(cont), .frc_in(frc),
      .nv_acal_in(nv_acal), .nv_params_in(nv_par), .nv_acal_wr_out(nv_wr),
      .nv_acal_data_out(nv_dat), .nv_params_wr_out(nvp_wr), .acal_active_out(acal_act),
      .cal_source_out(cal_src));

   mra_host u_host (
      .core_clk_in(core_clk), .i2c_byte_valid_in(b_val), .i2c_byte_in(b_dat),
      .cmd_ack_in(c_ack), .i2c_rd_start_out(rd_st), .i2c_byte_req_out(b_req),
      .i2c_nack_out(nack), .i2c_stop_out(stop), .mb_rd_start_out(mb_st),
      .cmd_valid_out(c_val), .cmd_func_out(c_func), .cmd_code_out(c_code),
      .cmd_arg_out(c_arg));

   // ***************************************************
   // helpers
   // ***************************************************
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %0h, expected %0h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      if (fail_count == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // crc over one word, msb first
   function automatic logic [7:0] crc8(input logic [15:0] d);
      logic [7:0] c;
      c = 8'hFF;
      for (int i = 15; i >= 0; i--) begin
         c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ 8'h31) : {c[6:0], 1'b0};
      end
      return c;
   endfunction
   function automatic logic [15:0] word_of(input int w);
      logic [95:0] all;
      all = {co2, temp, hum};
      return all[95 - 16 * w -: 16];
   endfunction
   function automatic logic [7:0] exp_byte(input int k);
      logic [15:0] w;
      w = word_of(k / 3);
      return (k % 3 == 0) ? w[15:8] : ((k % 3 == 1) ? w[7:0] : crc8(w));
   endfunction
   task automatic do_reset(input logic s);
      @(posedge core_clk);
      rst <= 1'b1;
      sel <= s;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
   endtask
   // cycles until new parameters are stored, bounded
   task automatic wait_found(output int n);
      n = 0;
      while (nvp_wr !== 1'b1 && n < 40) begin
         @(negedge core_clk);
         n++;
      end
   endtask

   // ***************************************************
   // scenarios
   // ***************************************************
   task automatic t_i2c_full();
      logic [7:0] b;
      logic v;
      u_host.i2c_open();
      for (int k = 0; k < 18; k++) begin
         u_host.i2c_get(b, v);
         cmp({v, b}, {1'b1, exp_byte(k)});
      end
      cmp(busy, 1'b0);
      u_host.i2c_get(b, v);
      cmp(v, 1'b0);
   endtask
   task automatic t_i2c_abort();
      logic [7:0] b;
      logic v;
      u_host.i2c_open();
      for (int k = 0; k < 4; k++) begin
         u_host.i2c_get(b, v);
         cmp({v, b}, {1'b1, exp_byte(k)});
      end
      u_host.i2c_abort();
      @(negedge core_clk);
      cmp(busy, 1'b0);
      u_host.i2c_get(b, v);
      cmp(v, 1'b0);
   endtask
   task automatic t_cmd();
      logic a;
      u_host.cmd(8'h00, 16'h5306, 16'h0001, a);
      cmp({a, acal_en, nv_wr, nv_dat}, 19'h40007);
      u_host.cmd(8'h00, 16'h5306, 16'h0002, a);
      cmp({a, acal_en}, 17'h00001);
      u_host.cmd(8'h00, 16'h5307, 16'h0000, a);
      cmp({a, acal_en}, 17'h00001);
      u_host.cmd(8'h00, 16'h5306, 16'h0000, a);
      cmp({a, acal_en, nv_wr, nv_dat}, 19'h40002);
   endtask
   task automatic t_search();
      logic a;
      int n;
      u_host.cmd(8'h00, 16'h5306, 16'h0001, a);
      n = 0;
      repeat (20) begin
         @(negedge core_clk);
         if (acal_act !== 1'b0 || nvp_wr !== 1'b0) n++;
      end
      cmp(n, 0);
      @(posedge core_clk);
      cont <= 1'b1;
      wait_found(n);
      cmp(n >= LO && n <= HI, 1'b1);
      @(negedge core_clk);
      cmp(cal_src, CAL_AUTO);
      u_host.cmd(8'h00, 16'h5306, 16'h0000, a);
      n = 0;
      repeat (20) begin
         @(negedge core_clk);
         if (cal_src !== CAL_AUTO || nvp_wr !== 1'b0) n++;
      end
      cmp(n, 0);
      @(posedge core_clk);
      frc <= 1'b1;
      @(posedge core_clk);
      frc <= 1'b0;
      @(negedge core_clk);
      cmp(cal_src, CAL_EXT);
   endtask
   task automatic t_power_loss();
      logic a;
      int n;
      u_host.cmd(8'h00, 16'h5306, 16'h0001, a);
      repeat (6) @(negedge core_clk);
      do_reset(1'b0);
      cmp({acal_en, cal_src}, {16'h0001, CAL_AUTO});
      wait_found(n);
      cmp({acal_act, 1'(n >= LO && n <= HI)}, 2'b11);
   endtask
   task automatic t_modbus();
      logic a;
      int n;
      do_reset(1'b1);
      u_host.cmd(8'h06, 16'h003A, 16'h0000, a);
      cmp({a, acal_en}, 17'h10000);
      u_host.cmd(8'h03, 16'h003A, 16'h0001, a);
      cmp({a, acal_en}, 17'h00000);
      u_host.mb_open();
      n = 0;
      repeat (12) begin
         @(negedge core_clk);
         if (mb_val === 1'b1) begin
            cmp({mb_idx, mb_word}, {n[2:0], word_of(n)});
            n++;
         end
      end
      cmp(n, 6);
   endtask

   // main sequence
   initial begin
      do_reset(1'b0);
      cmp({acal_en, acal_act, cal_src}, 19'h00000);
      t_i2c_full();
      t_i2c_abort();
      t_cmd();
      t_search();
      t_power_loss();
      t_modbus();
      end_of_test();
   end
   // watchdog against a hung handshake
   initial begin
      #20000;
      fail_count++;
      end_of_test();
   end
endmodule
